// [hdl/i2cs_consts.svh]
// constants for the serial control slave
`ifndef I2CS_CONSTS_SVH
`define I2CS_CONSTS_SVH
`define I2CS_ADDR_STRAP_LOW 7'h40
`define I2CS_ADDR_STRAP_HIGH 7'h41
`define I2CS_RW_READ 1'b1
`define I2CS_BITS_PER_BYTE 4'h8
`define I2CS_PTR_RESET 8'h00
`define I2CS_SYNC_STAGES 2
`endif

// [hdl/i2cs_pkg.sv]
// types for the serial control slave
`default_nettype none
package i2cs_pkg;
  typedef enum logic [2:0] {
    I2CS_IDLE = 3'b000,
    I2CS_ADDR = 3'b001,
    I2CS_ADDR_ACK = 3'b011,
    I2CS_RX = 3'b010,
    I2CS_RX_ACK = 3'b110,
    I2CS_TX = 3'b111,
    I2CS_TX_ACK = 3'b101
  } i2cs_state_type;

  typedef struct packed {
    logic valid;
    logic [7:0] addr;
    logic [7:0] data;
  } i2cs_wr_type;
endpackage : i2cs_pkg
`default_nettype wire

// [hdl/i2cs_sync.sv]
// two-flop synchroniser for a level
`default_nettype none
module i2cs_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stage1 <= '0;
      q_o <= '0;
    end else begin
      stage1 <= d_i;
      q_o <= stage1;
    end
  end
endmodule : i2cs_sync
`default_nettype wire

// [hdl/i2cs_slave.sv]
// serial control slave: bus engine and read port on the serial clock, write port on the core clock
// Behaviour
// - strap low: answer at 7-bit address 0x40 (write 0x80, read 0x81).
// - strap high: answer at 7-bit address 0x41 (write 0x82, read 0x83).
// - every byte is eight bits, most significant bit first.
// - receiver acknowledges in the clock period after the eighth bit.
// - data falling while clock high is start; rising is stop.
// - data changes only while clock low; sampled while clock high.
// - device holds data low for the whole acknowledge period.
// - any number of bytes accepted between start and stop.
// - every register reachable by single and multi-byte reads and writes.
// - multi-byte read returns successive registers while master acknowledges.
// - first written byte sets pointer; later bytes go to successive registers.
`include "i2cs_consts.svh"
`default_nettype none
module i2cs_slave
  import i2cs_pkg::*;
#(
  parameter int REG_COUNT = 256
) (
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic scl_clk_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  input wire logic addr_strap_i,
  output logic [7:0] wr_addr_o,
  output logic [7:0] wr_data_o,
  output logic wr_strobe_o,
  output logic [7:0] rd_addr_o,
  input wire logic [7:0] rd_data_i
);
  initial begin
    // the pointer is eight bits wide, so at most 256 registers
    if (REG_COUNT < 1 || REG_COUNT > 256) begin
      $error("REG_COUNT must be 1..256");
    end
    if (`I2CS_BITS_PER_BYTE != 4'h8) begin
      $error("byte length must be eight");
    end
  end

  function automatic logic [7:0] i2cs_next_ptr(input logic [7:0] p);
    i2cs_next_ptr = (p == 8'(REG_COUNT - 1)) ? 8'h00 : 8'(p + 8'h01);
  endfunction : i2cs_next_ptr

  // bit of the read byte driven for a given count, most significant first
  function automatic logic i2cs_tx_bit(input logic [7:0] b, input logic [3:0] n);
    i2cs_tx_bit = b[3'h7 - n[2:0]];
  endfunction : i2cs_tx_bit

  // strap is caught in the serial domain after two flops
  logic strap_s;
  logic [6:0] own_addr;
  i2cs_sync #(.WIDTH(1)) u_strap_sync (
    .clk_i(scl_clk_i),
    .rst_n_i(arst_n_i),
    .d_i(addr_strap_i),
    .q_o(strap_s)
  );
  assign own_addr = strap_s ? `I2CS_ADDR_STRAP_HIGH : `I2CS_ADDR_STRAP_LOW;

  // start/stop detection: sda edges while scl is high. scl is the clock here,
  // so sda edges are seen by sda-clocked toggles and qualified by scl level.
  logic start_tgl;
  logic stop_tgl;
  always_ff @(negedge sda_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      start_tgl <= 1'b0;
    end else if (scl_clk_i) begin
      start_tgl <= ~start_tgl;
    end
  end
  always_ff @(posedge sda_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      stop_tgl <= 1'b0;
    end else if (scl_clk_i) begin
      stop_tgl <= ~stop_tgl;
    end
  end

  // a condition is pending from its sda edge until the next scl rise takes it;
  // no resync: the bus keeps a whole scl low phase between the edge and that rise
  logic start_seen;
  logic stop_seen;
  logic start_ack;
  logic stop_ack;
  assign start_seen = start_tgl ^ start_ack;
  assign stop_seen = stop_tgl ^ stop_ack;

  i2cs_state_type state;
  logic [7:0] shift;
  logic [3:0] bit_cnt;
  logic rw_read;
  logic ptr_loaded;
  logic [7:0] ptr;
  logic [7:0] tx_byte;
  logic wr_tgl;
  logic [15:0] wr_word;
  logic byte_end;
  logic addr_match;
  logic [7:0] rx_byte;
  logic bit_taken;

  assign byte_end = (bit_cnt == `I2CS_BITS_PER_BYTE - 4'h1);
  assign rx_byte = {shift[6:0], sda_i};
  assign addr_match = (shift[6:0] == own_addr);
  // pointer and write only take a byte end when no condition is pending on this rise
  assign bit_taken = !start_seen && !stop_seen;

  // a pending condition restarts framing; the partial byte is dropped
  always_ff @(posedge scl_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      start_ack <= 1'b0;
      stop_ack <= 1'b0;
    end else begin
      start_ack <= start_tgl;
      stop_ack <= stop_tgl;
    end
  end

  // framing state: bits are sampled on scl rising, while scl is high
  always_ff @(posedge scl_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= I2CS_IDLE;
    end else if (start_seen) begin
      state <= I2CS_ADDR;
    end else if (stop_seen) begin
      state <= I2CS_IDLE;
    end else begin
      case (state)
        I2CS_IDLE: begin
          state <= I2CS_IDLE;
        end
        I2CS_ADDR: begin
          if (byte_end) begin
            state <= addr_match ? I2CS_ADDR_ACK : I2CS_IDLE;
          end
        end
        I2CS_ADDR_ACK: begin
          state <= rw_read ? I2CS_TX : I2CS_RX;
        end
        I2CS_RX: begin
          if (byte_end) begin
            state <= I2CS_RX_ACK;
          end
        end
        I2CS_RX_ACK: begin
          state <= I2CS_RX;
        end
        I2CS_TX: begin
          if (byte_end) begin
            state <= I2CS_TX_ACK;
          end
        end
        I2CS_TX_ACK: begin
          state <= sda_i ? I2CS_IDLE : I2CS_TX;
        end
        default: begin
          state <= I2CS_IDLE;
        end
      endcase
    end
  end

  // bit counter: the first rise after a start carries the first address bit
  always_ff @(posedge scl_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bit_cnt <= 4'h0;
    end else if (start_seen) begin
      bit_cnt <= 4'h1;
    end else if (stop_seen) begin
      bit_cnt <= 4'h0;
    end else begin
      case (state)
        I2CS_ADDR, I2CS_RX, I2CS_TX: begin
          bit_cnt <= 4'(bit_cnt + 4'h1);
        end
        default: begin
          bit_cnt <= 4'h0;
        end
      endcase
    end
  end

  // receive shifter and direction bit
  always_ff @(posedge scl_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      shift <= 8'h00;
      rw_read <= 1'b0;
    end else if (start_seen) begin
      shift <= {7'h00, sda_i};
    end else if (!stop_seen) begin
      if (state == I2CS_ADDR || state == I2CS_RX) begin
        shift <= rx_byte;
      end
      if (state == I2CS_ADDR && byte_end) begin
        rw_read <= (sda_i == `I2CS_RW_READ);
      end
    end
  end

  // register pointer: set by the first byte of a write, then steps per byte
  always_ff @(posedge scl_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ptr <= `I2CS_PTR_RESET;
      ptr_loaded <= 1'b0;
    end else if (start_seen) begin
      ptr_loaded <= 1'b0;
    end else if (bit_taken && byte_end) begin
      if (state == I2CS_RX && !ptr_loaded) begin
        ptr <= rx_byte;
        ptr_loaded <= 1'b1;
      end else if (state == I2CS_RX || state == I2CS_TX) begin
        ptr <= i2cs_next_ptr(ptr);
      end
    end
  end

  // write word: only a complete data byte after the pointer is handed over
  always_ff @(posedge scl_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_tgl <= 1'b0;
      wr_word <= 16'h0000;
    end else if (bit_taken && byte_end && state == I2CS_RX && ptr_loaded) begin
      wr_word <= {ptr, rx_byte};
      wr_tgl <= ~wr_tgl;
    end
  end

  // output side changes on scl falling, so sda moves only while scl is low
  logic drive_low;
  always_ff @(negedge scl_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      drive_low <= 1'b0;
    end else begin
      case (state)
        I2CS_ADDR_ACK, I2CS_RX_ACK: begin
          drive_low <= 1'b1;
        end
        I2CS_TX: begin
          drive_low <= ~i2cs_tx_bit(tx_byte, bit_cnt);
        end
        default: begin
          drive_low <= 1'b0;
        end
      endcase
    end
  end

  // the byte to send is loaded on the falling edge before its first bit
  always_ff @(negedge scl_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tx_byte <= 8'h00;
    end else if (state == I2CS_ADDR_ACK || state == I2CS_RX_ACK || state == I2CS_TX_ACK) begin
      tx_byte <= rd_data_i;
    end
  end
  // open drain: only ever pulls low, never asserts a start or stop itself
  assign sda_o = 1'b0;
  assign sda_oe_n_o = ~drive_low;
  // read data is taken a full bit before use; user keeps rd_data_i steady per pointer
  assign rd_addr_o = ptr;

  // write event crosses to the core clock by toggle; word is stable a full byte
  logic wr_tgl_s;
  logic wr_tgl_d;
  i2cs_sync #(.WIDTH(1)) u_wr_sync (
    .clk_i(core_clk_i),
    .rst_n_i(arst_n_i),
    .d_i(wr_tgl),
    .q_o(wr_tgl_s)
  );
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_tgl_d <= 1'b0;
      wr_strobe_o <= 1'b0;
      wr_addr_o <= 8'h00;
      wr_data_o <= 8'h00;
    end else begin
      wr_tgl_d <= wr_tgl_s;
      wr_strobe_o <= wr_tgl_s ^ wr_tgl_d;
      if (wr_tgl_s ^ wr_tgl_d) begin
        wr_addr_o <= wr_word[15:8];
        wr_data_o <= wr_word[7:0];
      end
    end
  end
endmodule : i2cs_slave
`default_nettype wire

// [tb/i2cs_monitor.sv]
// port checks for the serial control slave
`default_nettype none
module i2cs_monitor #(
  parameter int REG_COUNT = 256
) (
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic scl_clk_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_n_o,
  input wire logic addr_strap_i,
  input wire logic [7:0] wr_addr_o,
  input wire logic [7:0] wr_data_o,
  input wire logic wr_strobe_o,
  input wire logic [7:0] rd_addr_o,
  input wire logic [7:0] rd_data_i
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!arst_n_i);
  AST_OPEN_DRAIN: assert property (sda_o == 1'b0)
    else $error("data output high");
  AST_LOW_ONLY: assert property (!sda_oe_n_o |-> !sda_i)
    else $error("line not low while driven");
  AST_TAKE_SCL_LOW: assert property ($fell(sda_oe_n_o) |-> !scl_clk_i)
    else $error("line taken with clock high");
  AST_FREE_SCL_LOW: assert property ($rose(sda_oe_n_o) |-> !scl_clk_i)
    else $error("line freed with clock high");
  AST_STROBE_ONCE: assert property (wr_strobe_o |=> (!wr_strobe_o) [*8])
    else $error("write strobe too long");
  AST_ADDR_RANGE: assert property (wr_strobe_o |-> wr_addr_o < REG_COUNT)
    else $error("write index out of range");
  AST_ACK_AFTER: assert property (wr_strobe_o |-> ##[0:40] !sda_oe_n_o)
    else $error("written byte not acknowledged");
  AST_RESET_IDLE: assert property ($rose(arst_n_i) |-> sda_oe_n_o && !wr_strobe_o && rd_addr_o == 8'h00)
    else $error("not idle after reset");
endmodule : i2cs_monitor
bind i2cs_slave i2cs_monitor #(.REG_COUNT(REG_COUNT)) i2cs_monitor_i (.core_clk_i(core_clk_i),
  .arst_n_i(arst_n_i), .scl_clk_i(scl_clk_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o),
  .addr_strap_i(addr_strap_i), .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o), .wr_strobe_o(wr_strobe_o),
  .rd_addr_o(rd_addr_o), .rd_data_i(rd_data_i));
`default_nettype wire

// [tb/i2cs_master_model.sv]
// bus master model: makes the serial clock, start, stop and bytes
`default_nettype none
module i2cs_master_model (
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // data moves mid low phase, sampled mid high phase
  task automatic bit_io(input logic b, output logic r);
    sda_o = b;
    #16 scl_o = 1'b1;
    #16 r = sda_i;
    #16 scl_o = 1'b0;
    #16;
  endtask : bit_io
  // odd offset keeps the serial clock out of phase with the core clock
  task automatic idle(input int n);
    logic r;
    #1.3;
    repeat (n)
      bit_io(1'b1, r);
  endtask : idle
  task automatic start();
    #1.3 sda_o = 1'b1;
    #16 scl_o = 1'b1;
    #16 sda_o = 1'b0;
    #16 scl_o = 1'b0;
    #16;
  endtask : start
  task automatic stop();
    sda_o = 1'b0;
    #16 scl_o = 1'b1;
    #16 sda_o = 1'b1;
    #16;
  endtask : stop
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask : wbyte
  task automatic rbyte(output logic [7:0] d, input logic nack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, d[i]);
    bit_io(nack, r);
  endtask : rbyte
endmodule : i2cs_master_model
`default_nettype wire

// [tb/i2cs_slave_bench.sv]
// self-checking bench for the serial control slave
`default_nettype none
module i2cs_slave_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic strap = 1'b0;
  logic [7:0] rd_data = 8'h00;
  logic scl, sda_m, sda_o, sda_oe_n, wr_strobe;
  logic [7:0] wr_addr, wr_data, rd_addr, acks;
  logic [7:0] mem [256];
  logic [7:0] dat [4];
  logic [15:0] wq [$];
  int err_total = 0;
  int compares = 0;
  int cycles = 0;
  int seed = 60;
  wire logic sda = sda_m & (sda_oe_n | sda_o);
  always #2 core_clk = ~core_clk;
  i2cs_slave i2cs_slave_i (.core_clk_i(core_clk), .arst_n_i(arst_n), .scl_clk_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe_n_o(sda_oe_n), .addr_strap_i(strap), .wr_addr_o(wr_addr), .wr_data_o(wr_data),
    .wr_strobe_o(wr_strobe), .rd_addr_o(rd_addr), .rd_data_i(rd_data));
  i2cs_master_model i2cs_master_model_i (.sda_i(sda), .scl_o(scl), .sda_o(sda_m));
  task automatic results();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : results
  task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  function automatic logic [7:0] nxt(logic [7:0] p, int k);
    return p + 8'(k);
  endfunction : nxt
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    rd_data <= mem[rd_addr];
    if (wr_strobe === 1'b1) begin
      mem[wr_addr] <= wr_data;
      wq.push_back({wr_addr, wr_data});
    end
    if (cycles == 30000) begin
      err_total++;
      results();
    end
  end
  // cut > 0 ends the frame with a stop in the middle of a byte
  task automatic put(logic [7:0] dev, logic [7:0] ptr, int n, int cut);
    acks = 8'h00;
    i2cs_master_model_i.start();
    i2cs_master_model_i.wbyte(dev, acks[0]);
    i2cs_master_model_i.wbyte(ptr, acks[1]);
    for (int i = 0; i < n; i++)
      i2cs_master_model_i.wbyte(dat[i], acks[i + 2]);
    repeat (cut)
      i2cs_master_model_i.bit_io(1'b0, acks[7]);
    i2cs_master_model_i.stop();
  endtask : put
  task automatic get(logic [7:0] dev, logic [7:0] ptr, int n);
    acks = 8'h00;
    i2cs_master_model_i.start();
    i2cs_master_model_i.wbyte(dev & 8'hFE, acks[0]);
    i2cs_master_model_i.wbyte(ptr, acks[1]);
    i2cs_master_model_i.start();
    i2cs_master_model_i.wbyte(dev, acks[2]);
    for (int i = 0; i < n; i++)
      i2cs_master_model_i.rbyte(dat[i], i == n - 1);
    i2cs_master_model_i.stop();
  endtask : get
  initial begin
    logic [7:0] p;
    logic [7:0] e [4];
    for (int i = 0; i < 256; i++)
      mem[i] = 8'($random(seed));
    repeat (16) @(posedge core_clk);
    arst_n <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      p = k ? 8'($random(seed)) : 8'hFE;
      i2cs_master_model_i.idle(2);
      for (int i = 0; i < 4; i++)
        dat[i] = 8'($random(seed));
      e = dat;
      wq.delete();
      put(8'h80 | 8'(k << 1), p, 3, 0);
      chk("write acks", 16'h1F, {8'h00, acks});
      repeat (20) @(posedge core_clk);
      for (int i = 0; i < 3; i++)
        chk("write", {nxt(p, i), e[i]}, wq[i]);
      get(8'h81 | 8'(k << 1), p, 3);
      chk("read acks", 16'h07, {8'h00, acks});
      chk("released", 16'h1, {15'h0, sda_oe_n});
      for (int i = 0; i < 3; i++)
        chk("read", {8'h00, e[i]}, {8'h00, dat[i]});
      wq.delete();
      put(8'h82 ^ 8'(k << 1), p, 0, 0);
      chk("foreign acks", 16'h0, {8'h00, acks});
      put(8'h80 | 8'(k << 1), p, 0, 4);
      repeat (20) @(posedge core_clk);
      chk("dropped", 16'h0, 16'(wq.size()));
      arst_n <= 1'b0;
      strap <= 1'b1;
      repeat (16) @(posedge core_clk);
      arst_n <= 1'b1;
    end
    results();
  end
endmodule : i2cs_slave_bench
`default_nettype wire
